// [hw/tct_pkg.sv]
// Shared constants and types for the transactional conflict tracker
package tct_pkg;
  // ==========================================================
  // Cache geometry
  localparam int        LINE_OFF_BITS = 6;     // 64-byte lines
  localparam logic [6:0] LINE_BYTES   = 7'h40;
  localparam int        SET_BITS      = 6;     // 64 sets
  localparam int        TAG_LSB       = LINE_OFF_BITS + SET_BITS;
  localparam int        DEF_WAYS      = 8;     // Documented associativity
  localparam int        BLOOM_BITS    = 8;     // Index width of filter
  // ==========================================================
  // Nesting limits
  localparam logic [2:0] EXPL_MAX_DEPTH  = 3'h7;
  localparam logic [2:0] ELIDE_MAX_DEPTH = 3'h1;
  // ==========================================================
  // Abort cause codes
  localparam logic [2:0] CAUSE_NONE     = 3'h0;
  localparam logic [2:0] CAUSE_CONFLICT = 3'h1;
  localparam logic [2:0] CAUSE_CAPACITY = 3'h2;
  localparam logic [2:0] CAUSE_LOCK     = 3'h3;
  localparam logic [2:0] CAUSE_EXPLICIT = 3'h4;
  // ==========================================================
  // Access prefix codes
  localparam logic [1:0] PFX_NONE    = 2'h0;
  localparam logic [1:0] PFX_ACQUIRE = 2'h1;
  localparam logic [1:0] PFX_RELEASE = 2'h2;
  // ==========================================================
  // Transaction modes
  typedef enum logic [1:0] {
    MODE_IDLE,
    MODE_ELIDE,
    MODE_EXPLICIT
  } tct_mode_e;
endpackage

// [hw/tct_tracker.sv]
// Read/write set tracker with conflict, capacity and lock-rule aborts
//
// What this block does
// - Record transactional reads and writes as read/write bits in cache ways.
// - Evicted read lines go to a hashed filter; a false write match aborts.
// - A write needing a ninth way in a full eight-way set aborts.
// - No capacity is promised; any tracked eviction or overflow may abort.
// - Sibling thread evictions remove tracked lines and may abort.
// - Every remote ownership request aborts if the line is tracked here.
// - Elision start puts the lock line in the read set automatically.
// - A remote write to the lock line aborts the eliding transaction.
// - Lock not in write set; release must restore the old lock value.
// - Release must match acquire size and address; crossing locks abort.
// - Exact aligned lock reads are fine; partial or unaligned ones abort.
// - Any non-release write to the lock during elision aborts.
// - Explicit abort instruction ends the current transaction at once.
// - All conflict checks use 64-byte line addresses.
// - Remote read of write set, or remote write of either set, conflicts.
// - After an elision abort the next acquire runs without elision.
// - Nesting depth up to 7 in explicit mode and 1 in elision mode.
`timescale 1ns/1ns
`default_nettype none

module tct_tracker #(
  parameter int AW    = 32,
  parameter int NWAYS = tct_pkg::DEF_WAYS
) (
  input  wire logic          clk_in,
  input  wire logic          rst_b_in,
  input  wire logic          xbegin_in,
  input  wire logic          xend_in,
  input  wire logic          explicit_abort_instruction_in,
  input  wire logic          acc_valid_in,
  input  wire logic          acc_write_in,
  input  wire logic [1:0]    acc_prefix_in,
  input  wire logic [1:0]    acc_size_in,
  input  wire logic [AW-1:0] acc_addr_in,
  input  wire logic [63:0]   acc_wdata_in,
  input  wire logic [63:0]   acc_rdata_in,
  input  wire logic          snp_valid_in,
  input  wire logic          snp_write_in,
  input  wire logic [AW-1:0] snp_addr_in,
  input  wire logic          sib_fill_valid_in,
  input  wire logic [AW-1:0] sib_fill_addr_in,
  output logic               in_txn_out,
  output logic               elide_out,
  output logic [2:0]         depth_out,
  output logic               abort_out,
  output logic [2:0]         abort_cause_out,
  output logic               commit_out,
  output logic               noelide_out
);
  // ==========================================================
  // Geometry
  localparam int NSETS = 1 << tct_pkg::SET_BITS;
  localparam int TAG_W = AW - tct_pkg::TAG_LSB;
  localparam int WW    = $clog2(NWAYS);
  localparam int NBLM  = 1 << tct_pkg::BLOOM_BITS;

  // ==========================================================
  // State
  tct_pkg::tct_mode_e mode_r, mode_nxt;
  logic [TAG_W-1:0]   tag_r [NSETS][NWAYS];
  logic [TAG_W-1:0]   tag_nxt [NSETS][NWAYS];
  logic [NWAYS-1:0]   rd_r [NSETS];
  logic [NWAYS-1:0]   rd_nxt [NSETS];
  logic [NWAYS-1:0]   wr_r [NSETS];
  logic [NWAYS-1:0]   wr_nxt [NSETS];
  logic [NBLM-1:0]    bloom_r, bloom_nxt;
  logic [AW-1:0]      lock_addr_r, lock_addr_nxt;
  logic [1:0]         lock_size_r, lock_size_nxt;
  logic [63:0]        lock_val_r, lock_val_nxt;
  logic [2:0]         depth_r, depth_nxt;
  logic               in_txn_r, in_txn_nxt;
  logic               elide_r, elide_nxt;
  logic               abort_r, abort_nxt;
  logic [2:0]         cause_r, cause_nxt;
  logic               commit_r, commit_nxt;
  logic               noelide_r, noelide_nxt;

  // Working signals
  logic [tct_pkg::SET_BITS-1:0] a_set, s_set, f_set;
  logic [TAG_W-1:0]   a_tag, s_tag, f_tag;
  logic               a_hit, a_free, s_hit_rd, s_hit_wr, s_bloom;
  logic [WW-1:0]      a_hway, a_fway;
  logic [6:0]         a_lo, a_hi, l_lo, l_hi;
  logic               same_line, overlap, exact;
  logic               abt_expl, abt_lock, abt_cap, abt_conf, do_commit;
  logic               elide_start, lock_wr_bad;
  logic [63:0]        mask;

  // Hash of a line address into the read-set filter
  function automatic logic [tct_pkg::BLOOM_BITS-1:0] bidx(
    input logic [AW-1:0] a
  );
    bidx = a[13:6] ^ a[21:14];
  endfunction

  // Byte mask for an access of the given size
  function automatic logic [63:0] size_mask(input logic [1:0] s);
    case (s)
      2'h0:    size_mask = 64'h0000_0000_0000_00ff;
      2'h1:    size_mask = 64'h0000_0000_0000_ffff;
      2'h2:    size_mask = 64'h0000_0000_ffff_ffff;
      default: size_mask = 64'hffff_ffff_ffff_ffff;
    endcase
  endfunction

  // ==========================================================
  // Next-state logic for the whole tracker
  always_comb
  begin
    mode_nxt      = mode_r;
    tag_nxt       = tag_r;
    rd_nxt        = rd_r;
    wr_nxt        = wr_r;
    bloom_nxt     = bloom_r;
    lock_addr_nxt = lock_addr_r;
    lock_size_nxt = lock_size_r;
    lock_val_nxt  = lock_val_r;
    depth_nxt     = depth_r;
    noelide_nxt   = noelide_r;
    cause_nxt     = tct_pkg::CAUSE_NONE;
    abt_expl      = 1'b0;
    abt_lock      = 1'b0;
    abt_cap       = 1'b0;
    abt_conf      = 1'b0;
    do_commit     = 1'b0;
    elide_start   = 1'b0;
    lock_wr_bad   = 1'b0;
    // Line-granular set and tag split
    a_set = acc_addr_in[tct_pkg::TAG_LSB-1:tct_pkg::LINE_OFF_BITS];
    a_tag = acc_addr_in[AW-1:tct_pkg::TAG_LSB];
    s_set = snp_addr_in[tct_pkg::TAG_LSB-1:tct_pkg::LINE_OFF_BITS];
    s_tag = snp_addr_in[AW-1:tct_pkg::TAG_LSB];
    f_set = sib_fill_addr_in[tct_pkg::TAG_LSB-1:tct_pkg::LINE_OFF_BITS];
    f_tag = sib_fill_addr_in[AW-1:tct_pkg::TAG_LSB];
    a_hit = 1'b0;
    a_free = 1'b0;
    a_hway = '0;
    a_fway = '0;
    s_hit_rd = 1'b0;
    s_hit_wr = 1'b0;
    for (int w = NWAYS - 1; w >= 0; w--)
    begin
      if ((rd_r[a_set][w] | wr_r[a_set][w]) && tag_r[a_set][w] == a_tag)
      begin
        a_hit  = 1'b1;
        a_hway = WW'(w);
      end
      if (!(rd_r[a_set][w] | wr_r[a_set][w]))
      begin
        a_free = 1'b1;
        a_fway = WW'(w);
      end
      if (tag_r[s_set][w] == s_tag)
      begin
        s_hit_rd = s_hit_rd | rd_r[s_set][w];
        s_hit_wr = s_hit_wr | wr_r[s_set][w];
      end
    end
    s_bloom = bloom_r[bidx(snp_addr_in)];
    // Lock byte range against access byte range
    a_lo = {1'b0, acc_addr_in[tct_pkg::LINE_OFF_BITS-1:0]};
    a_hi = a_lo + 7'(4'h1 << acc_size_in);
    l_lo = {1'b0, lock_addr_r[tct_pkg::LINE_OFF_BITS-1:0]};
    l_hi = l_lo + 7'(4'h1 << lock_size_r);
    same_line = acc_addr_in[AW-1:tct_pkg::LINE_OFF_BITS] ==
                lock_addr_r[AW-1:tct_pkg::LINE_OFF_BITS];
    overlap = same_line && a_lo < l_hi && l_lo < a_hi;
    exact = acc_addr_in == lock_addr_r && acc_size_in == lock_size_r;
    mask = size_mask(acc_size_in);

    // Explicit begin, end and abort instructions
    if (xbegin_in)
    begin
      if (mode_r == tct_pkg::MODE_IDLE)
      begin
        mode_nxt  = tct_pkg::MODE_EXPLICIT;
        depth_nxt = 3'h1;
      end
      else if (mode_r == tct_pkg::MODE_EXPLICIT &&
               depth_r < tct_pkg::EXPL_MAX_DEPTH)
        depth_nxt = depth_r + 3'h1;
      else
        abt_cap = 1'b1;
    end
    if (xend_in && mode_r == tct_pkg::MODE_EXPLICIT)
    begin
      if (depth_r == 3'h1)
        do_commit = 1'b1;
      else
        depth_nxt = depth_r - 3'h1;
    end
    if (explicit_abort_instruction_in && mode_r != tct_pkg::MODE_IDLE)
      abt_expl = 1'b1;

    // Local accesses: elision entry, lock rules, set tracking
    if (acc_valid_in)
    begin
      if (mode_r == tct_pkg::MODE_IDLE &&
          acc_prefix_in == tct_pkg::PFX_ACQUIRE)
      begin
        if (noelide_r)
          noelide_nxt = 1'b0;
        else if (a_hi > tct_pkg::LINE_BYTES)
          abt_lock = 1'b1;
        else
        begin
          // Lock goes to read set only, old value kept for release
          elide_start   = 1'b1;
          mode_nxt      = tct_pkg::MODE_ELIDE;
          depth_nxt     = tct_pkg::ELIDE_MAX_DEPTH;
          lock_addr_nxt = acc_addr_in;
          lock_size_nxt = acc_size_in;
          lock_val_nxt  = acc_rdata_in & mask;
          tag_nxt[a_set][a_fway] = a_tag;
          rd_nxt[a_set][a_fway]  = 1'b1;
        end
      end
      else if (mode_r == tct_pkg::MODE_ELIDE &&
               acc_prefix_in == tct_pkg::PFX_RELEASE)
      begin
        if (exact && (acc_wdata_in & mask) == lock_val_r)
          do_commit = 1'b1;
        else
          abt_lock = 1'b1;
      end
      else if (mode_r == tct_pkg::MODE_ELIDE &&
               acc_prefix_in == tct_pkg::PFX_ACQUIRE)
        abt_cap = 1'b1;
      else if (mode_r == tct_pkg::MODE_ELIDE && overlap)
      begin
        lock_wr_bad = acc_write_in;
        abt_lock = acc_write_in || !exact;
      end
      else if (mode_r != tct_pkg::MODE_IDLE)
      begin
        if (a_hit)
        begin
          rd_nxt[a_set][a_hway] = rd_r[a_set][a_hway] | !acc_write_in;
          wr_nxt[a_set][a_hway] = wr_r[a_set][a_hway] | acc_write_in;
        end
        else if (a_free)
        begin
          tag_nxt[a_set][a_fway] = a_tag;
          rd_nxt[a_set][a_fway]  = !acc_write_in;
          wr_nxt[a_set][a_fway]  = acc_write_in;
        end
        else if (acc_write_in)
          abt_cap = 1'b1;
        else
          bloom_nxt[bidx(acc_addr_in)] = 1'b1;
      end
    end

    // Sibling fill into a fully tracked set evicts the last way
    if (sib_fill_valid_in && mode_r != tct_pkg::MODE_IDLE &&
        &(rd_r[f_set] | wr_r[f_set]) &&
        tag_r[f_set][NWAYS-1] != f_tag)
    begin
      if (wr_r[f_set][NWAYS-1])
        abt_cap = 1'b1;
      else
        bloom_nxt[bidx({tag_r[f_set][NWAYS-1], f_set,
                        {tct_pkg::LINE_OFF_BITS{1'b0}}})] = 1'b1;
      rd_nxt[f_set][NWAYS-1] = 1'b0;
      wr_nxt[f_set][NWAYS-1] = 1'b0;
    end

    // Remote coherence traffic against the tracked sets
    if (snp_valid_in && mode_r != tct_pkg::MODE_IDLE)
      abt_conf = snp_write_in ? (s_hit_rd | s_hit_wr | s_bloom)
                              : s_hit_wr;

    // Abort priority, then clearing of all tracking
    abort_nxt  = abt_expl | abt_lock | abt_cap | abt_conf;
    commit_nxt = do_commit && !abort_nxt;
    if (abt_expl)
      cause_nxt = tct_pkg::CAUSE_EXPLICIT;
    else if (abt_lock)
      cause_nxt = tct_pkg::CAUSE_LOCK;
    else if (abt_cap)
      cause_nxt = tct_pkg::CAUSE_CAPACITY;
    else if (abt_conf)
      cause_nxt = tct_pkg::CAUSE_CONFLICT;
    if (abort_nxt && (mode_r == tct_pkg::MODE_ELIDE ||
                      (mode_r == tct_pkg::MODE_IDLE && acc_valid_in &&
                       acc_prefix_in == tct_pkg::PFX_ACQUIRE)))
      noelide_nxt = 1'b1;
    if (abort_nxt || do_commit)
    begin
      mode_nxt  = tct_pkg::MODE_IDLE;
      depth_nxt = 3'h0;
      bloom_nxt = '0;
      for (int s = 0; s < NSETS; s++)
      begin
        rd_nxt[s] = '0;
        wr_nxt[s] = '0;
      end
    end
    in_txn_nxt = mode_nxt != tct_pkg::MODE_IDLE;
    elide_nxt  = mode_nxt == tct_pkg::MODE_ELIDE;
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      mode_r      <= tct_pkg::MODE_IDLE;
      bloom_r     <= '0;
      lock_addr_r <= '0;
      lock_size_r <= 2'h0;
      lock_val_r  <= 64'h0000_0000_0000_0000;
      depth_r     <= 3'h0;
      in_txn_r    <= 1'b0;
      elide_r     <= 1'b0;
      abort_r     <= 1'b0;
      cause_r     <= tct_pkg::CAUSE_NONE;
      commit_r    <= 1'b0;
      noelide_r   <= 1'b0;
      for (int s = 0; s < NSETS; s++)
      begin
        rd_r[s] <= '0;
        wr_r[s] <= '0;
        for (int w = 0; w < NWAYS; w++)
          tag_r[s][w] <= '0;
      end
    end
    else
    begin
      mode_r      <= mode_nxt;
      tag_r       <= tag_nxt;
      rd_r        <= rd_nxt;
      wr_r        <= wr_nxt;
      bloom_r     <= bloom_nxt;
      lock_addr_r <= lock_addr_nxt;
      lock_size_r <= lock_size_nxt;
      lock_val_r  <= lock_val_nxt;
      depth_r     <= depth_nxt;
      in_txn_r    <= in_txn_nxt;
      elide_r     <= elide_nxt;
      abort_r     <= abort_nxt;
      cause_r     <= cause_nxt;
      commit_r    <= commit_nxt;
      noelide_r   <= noelide_nxt;
    end
  end

  assign in_txn_out      = in_txn_r;
  assign elide_out       = elide_r;
  assign depth_out       = depth_r;
  assign abort_out       = abort_r;
  assign abort_cause_out = cause_r;
  assign commit_out      = commit_r;
  assign noelide_out     = noelide_r;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  sequence s_lock_store;
    elide_r && acc_valid_in && lock_wr_bad && !explicit_abort_instruction_in;
  endsequence
  sequence s_remote_hit;
    in_txn_r && snp_valid_in && snp_write_in && (s_hit_rd || s_hit_wr) &&
    !abt_expl && !abt_lock && !abt_cap;
  endsequence

  a_abort_clears: assert property (
    abort_r |-> !in_txn_r && bloom_r == '0 && depth_r == 3'h0)
    else $error("abort left tracking state");
  a_explicit_abort_instruction_cause: assert property (
    in_txn_r && explicit_abort_instruction_in |=>
      abort_r && cause_r == tct_pkg::CAUSE_EXPLICIT)
    else $error("explicit abort not reported");
  a_depth_expl: assert property (
    in_txn_r && !elide_r |->
      depth_r >= 3'h1 && depth_r <= tct_pkg::EXPL_MAX_DEPTH)
    else $error("explicit nesting depth out of range");
  a_depth_elide: assert property (
    elide_r |-> depth_r == tct_pkg::ELIDE_MAX_DEPTH)
    else $error("elision depth not one");
  a_cap_write: assert property (
    abt_cap && !abt_expl && !abt_lock |=>
      abort_r && cause_r == tct_pkg::CAUSE_CAPACITY)
    else $error("overflow did not abort for capacity");
  a_remote_write: assert property (
    s_remote_hit |=> abort_r ##0 cause_r == tct_pkg::CAUSE_CONFLICT)
    else $error("remote write to tracked line missed");
  a_lock_store: assert property (
    s_lock_store |=> abort_r && cause_r == tct_pkg::CAUSE_LOCK)
    else $error("store to elided lock not aborted");
  a_elide_restart: assert property (
    elide_r && !commit_nxt ##1 abort_r |-> noelide_r)
    else $error("elision abort did not disable elision");
  a_commit_clean: assert property (
    commit_r |-> !in_txn_r && !abort_r && $past(in_txn_r))
    else $error("commit without a live transaction");
  a_elide_entry: assert property (
    elide_start |=> elide_r && in_txn_r && !abort_r)
    else $error("elision entry did not start a transaction");

endmodule

`default_nettype wire

// [tb/tct_remote_model.sv]
// Model of remote processors and the sibling thread issuing cache traffic
`timescale 1ns/1ns
`default_nettype none

module tct_remote_model #(
  parameter int AW = 32
) (
  input  wire logic          clk_in,
  output logic               snp_valid_out,
  output logic               snp_write_out,
  output logic [AW-1:0]      snp_addr_out,
  output logic               sib_fill_valid_out,
  output logic [AW-1:0]      sib_fill_addr_out
);
  // ==========================================================
  // Quiet fabric at time zero
  initial
  begin
    snp_valid_out      = 1'b0;
    snp_write_out      = 1'b0;
    snp_addr_out       = '0;
    sib_fill_valid_out = 1'b0;
    sib_fill_addr_out  = '0;
  end

  // ==========================================================
  // One coherence request; a write asks for ownership whatever its data
  task automatic snoop(input logic wr, input logic [AW-1:0] a);
    @(negedge clk_in);
    snp_valid_out = 1'b1;
    snp_write_out = wr;
    snp_addr_out  = a;
    @(negedge clk_in);
    snp_valid_out = 1'b0;
    snp_write_out = ~wr;  // Released lines must not look valid
    snp_addr_out  = ~a;
  endtask

  // One fill by the sibling thread into the shared first-level cache
  task automatic fill(input logic [AW-1:0] a);
    @(negedge clk_in);
    sib_fill_valid_out = 1'b1;
    sib_fill_addr_out  = a;
    @(negedge clk_in);
    sib_fill_valid_out = 1'b0;
    sib_fill_addr_out  = ~a;  // No stale address after the pulse
  endtask
endmodule
`default_nettype wire

// [tb/transactional_conflict_tracker_tb_top.sv]
// Self-checking bench for the transactional conflict tracker
`timescale 1ns/1ns
`default_nettype none

module transactional_conflict_tracker_tb_top;
  localparam int         AW = 32;
  localparam logic [31:0] LK = 32'h0000_1000;  // Lock address
  localparam logic [31:0] XA = 32'h0000_2040;  // Data line
  logic          clk_in, rst_b_in, xbegin_in, xend_in, explicit_abort_instruction_in;
  logic          acc_valid_in, acc_write_in;
  logic [1:0]    acc_prefix_in, acc_size_in;
  logic [AW-1:0] acc_addr_in, snp_addr_in, sib_fill_addr_in;
  logic [63:0]   acc_wdata_in, acc_rdata_in;
  logic          snp_valid_in, snp_write_in, sib_fill_valid_in;
  logic          in_txn_out, elide_out, abort_out, commit_out, noelide_out;
  logic [2:0]    depth_out, abort_cause_out;
  logic [7:0]    st;
  int            failures, n_tests;

  tct_tracker #(.AW(AW), .NWAYS(8)) DUT (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .xbegin_in(xbegin_in),
    .xend_in(xend_in), .explicit_abort_instruction_in(explicit_abort_instruction_in), .acc_valid_in(acc_valid_in),
    .acc_write_in(acc_write_in), .acc_prefix_in(acc_prefix_in),
    .acc_size_in(acc_size_in), .acc_addr_in(acc_addr_in),
    .acc_wdata_in(acc_wdata_in), .acc_rdata_in(acc_rdata_in),
    .snp_valid_in(snp_valid_in), .snp_write_in(snp_write_in),
    .snp_addr_in(snp_addr_in), .sib_fill_valid_in(sib_fill_valid_in),
    .sib_fill_addr_in(sib_fill_addr_in), .in_txn_out(in_txn_out),
    .elide_out(elide_out), .depth_out(depth_out), .abort_out(abort_out),
    .abort_cause_out(abort_cause_out), .commit_out(commit_out),
    .noelide_out(noelide_out));

  tct_remote_model #(.AW(AW)) u_remote (
    .clk_in(clk_in), .snp_valid_out(snp_valid_in),
    .snp_write_out(snp_write_in), .snp_addr_out(snp_addr_in),
    .sib_fill_valid_out(sib_fill_valid_in),
    .sib_fill_addr_out(sib_fill_addr_in));

  // Packed view: txn, elide, depth, abort, commit, noelide
  assign st = {in_txn_out, elide_out, depth_out, abort_out, commit_out,
               noelide_out};

  // ==========================================================
  // Clock and watchdog
  always #5 clk_in = ~clk_in;
  initial
  begin
    repeat (20000) @(posedge clk_in);
    failures++;
    summarize();
  end

  // ==========================================================
  // Shared helpers
  task automatic summarize();
    if (failures == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Cause 0 means no abort pulse expected
  task automatic chk_abt(input logic [2:0] c);
    chk("abort", {4'h0, c != 3'h0, c}, {4'h0, abort_out, abort_cause_out});
  endtask

  // One instruction pulse: {begin, end, abort}
  task automatic instr(input logic [2:0] w);
    @(negedge clk_in);
    {xbegin_in, xend_in, explicit_abort_instruction_in} = w;
    @(negedge clk_in);
    {xbegin_in, xend_in, explicit_abort_instruction_in} = 3'h0;
  endtask

  // One local access held for one cycle, read data given with it
  task automatic acc(input logic wr, input logic [1:0] pf,
                     input logic [1:0] sz, input logic [31:0] a,
                     input logic [63:0] wd);
    @(negedge clk_in);
    acc_valid_in  = 1'b1;
    acc_write_in  = wr;
    acc_prefix_in = pf;
    acc_size_in   = sz;
    acc_addr_in   = a;
    acc_wdata_in  = wd;
    acc_rdata_in  = 64'h0000_0000_0000_0000;  // Lock seen free
    @(negedge clk_in);
    acc_valid_in  = 1'b0;
    acc_addr_in   = ~a;
  endtask

  task automatic acquire_lock();
    acc(1'b1, tct_pkg::PFX_ACQUIRE, 2'h2, LK, 64'h0000_0000_0000_0001);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_elide_commit();
    acquire_lock();
    chk("elide start", 8'hC8, st);
    acc(1'b0, tct_pkg::PFX_NONE, 2'h2, LK, 64'h0);
    chk_abt(3'h0);
    u_remote.snoop(1'b0, LK + 32'h8);
    chk_abt(3'h0);
    acc(1'b1, tct_pkg::PFX_RELEASE, 2'h2, LK, 64'h0);
    chk("elide commit", 8'h02, st);
  endtask

  task automatic t_elide_faults();
    for (int k = 0; k < 6; k++)
    begin
      acquire_lock();
      case (k)
        0: acc(1'b1, tct_pkg::PFX_NONE, 2'h2, LK, 64'h0);
        1: acc(1'b1, tct_pkg::PFX_RELEASE, 2'h2, LK, 64'h5);
        2: acc(1'b1, tct_pkg::PFX_RELEASE, 2'h2, LK + 32'h4, 64'h0);
        3: acc(1'b1, tct_pkg::PFX_RELEASE, 2'h3, LK, 64'h0);
        4: acc(1'b0, tct_pkg::PFX_NONE, 2'h2, LK + 32'h2, 64'h0);
        default: u_remote.snoop(1'b1, LK + 32'h20);
      endcase
      chk_abt(k == 5 ? tct_pkg::CAUSE_CONFLICT
                     : tct_pkg::CAUSE_LOCK);
      chk("noelide set", 8'h01, {7'h0, noelide_out});
      acquire_lock();
      chk("plain acquire", 8'h00, st);
    end
    acc(1'b1, tct_pkg::PFX_ACQUIRE, 2'h2, LK + 32'h3E, 64'h1);
    chk_abt(tct_pkg::CAUSE_LOCK);
    chk("cross lock", 8'h01, {in_txn_out, 6'h0, noelide_out});
    acquire_lock();
  endtask

  task automatic t_explicit_conflict();
    for (int k = 0; k < 3; k++)
    begin
      instr(3'h4);
      chk("begin", 8'h88, st);
      acc(k != 2, tct_pkg::PFX_NONE, 2'h3, XA, 64'h0);
      u_remote.snoop(k != 0, XA + 32'h3F - 32'(k));
      chk_abt(tct_pkg::CAUSE_CONFLICT);
      chk("idle after", 8'h00, {in_txn_out, 7'h0});
    end
    instr(3'h4);
    u_remote.snoop(1'b1, XA);
    chk_abt(3'h0);
    acc(1'b0, tct_pkg::PFX_NONE, 2'h2, XA, 64'h0);
    u_remote.snoop(1'b0, XA);
    chk_abt(3'h0);
    u_remote.snoop(1'b1, XA + 32'h40);
    chk_abt(3'h0);
    instr(3'h2);
    chk("commit", 8'h02, st);
  endtask

  task automatic t_capacity();
    instr(3'h4);
    for (int i = 0; i < 9; i++)
    begin
      acc(1'b1, tct_pkg::PFX_NONE, 2'h3, {16'h0000, 4'(i), 12'h080}, 64'h0);
      chk_abt(i == 8 ? tct_pkg::CAUSE_CAPACITY : 3'h0);
    end
    instr(3'h4);
    for (int i = 0; i < 8; i++)
      acc(1'b1, tct_pkg::PFX_NONE, 2'h3, {16'h0000, 4'(i), 12'h100}, 64'h0);
    chk_abt(3'h0);
    u_remote.fill(32'h0000_9100);
    chk_abt(tct_pkg::CAUSE_CAPACITY);
    // True filter hit first, then an unrelated line with the same hash
    for (int j = 0; j < 2; j++)
    begin
      instr(3'h4);
      for (int i = 0; i < 9; i++)
        acc(1'b0, tct_pkg::PFX_NONE, 2'h3, {16'h0000, 4'(i), 12'h0C0}, 64'h0);
      u_remote.snoop(1'b0, 32'h0000_80C0);
      chk_abt(3'h0);
      u_remote.snoop(1'b1, j == 0 ? 32'h0000_80C0 : 32'h0000_4000);
      chk_abt(tct_pkg::CAUSE_CONFLICT);
    end
  endtask

  task automatic t_nesting();
    for (int i = 0; i < 7; i++)
      instr(3'h4);
    chk("depth", 8'hB8, st);
    instr(3'h4);
    chk_abt(tct_pkg::CAUSE_CAPACITY);
    instr(3'h4);
    instr(3'h4);
    instr(3'h2);
    chk("unnest", 8'h88, st);
    instr(3'h1);
    chk_abt(tct_pkg::CAUSE_EXPLICIT);
    chk("cleared", 8'h00, {in_txn_out, elide_out, depth_out, 3'h0});
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    failures = 0;
    n_tests  = 0;
    clk_in   = 1'b0;
    rst_b_in = 1'b0;
    {xbegin_in, xend_in, explicit_abort_instruction_in} = 3'h0;
    {acc_valid_in, acc_write_in} = 2'h0;
    acc_prefix_in = 2'h0;
    acc_size_in   = 2'h0;
    acc_addr_in   = '0;
    acc_wdata_in  = 64'h0;
    acc_rdata_in  = 64'h0;
    repeat (3) @(posedge clk_in);
    @(negedge clk_in);
    chk("reset", 8'h00, st);
    rst_b_in = 1'b1;
    t_elide_commit();
    t_elide_faults();
    t_explicit_conflict();
    t_capacity();
    t_nesting();
    summarize();
  end
endmodule
`default_nettype wire
